// ### rtl/gap_panel.sv
/*
  gas alarm panel: threshold compare, relay banks, panel switches, paging, clock.
  assumes raw switch pins asynchronous; readings from a poll engine on clk.
*/
`timescale 1ns/10ps
`include "gap_map.svh"
// Functional notes
// - menu switch enters menu, then steps back
// - menu active freezes readings and alarms
// - up/down move menu cursor
// - enter accepts selection in menu
// - reset releases latched relays once cleared
// - ack silences active silenceable relays
// - enter resets/acks only on main display
// - display holds or cycles alarm pages
// - arrows page manually; 15 s resumes cycling
// - four leds mirror level and fault outputs
// - no alarms: cycle sensor pages only
// - tag shows alarm, fault or link failure
// - three thresholds in 5% steps
// - ascending above, descending below trips
// - eight banks, three levels plus fault
// - latch/energize/silence set per bank
// - inhibit suppresses alarm relays
// - test ramps 5% up, down, exits
// - 24h time and date, user settable
// - log record on every poll on main display
// - remote button resets and acks too
// - count sensors at valid addresses
// - energized: contact held closed when idle
// - de-energized: contact open when idle
// - non-latching releases when cause clears
// - non-silenceable ignores acknowledge
module gap_panel
  import gap_pkg::*;
#(
  parameter int unsigned IDLE_CYC = `GAP_IDLE_CYC,
  parameter int unsigned TICK_CYC = `GAP_TICK_CYC,
  parameter int unsigned PAGE_CYC = `GAP_PAGE_CYC
)(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output      logic [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output      logic        wb_ack_o,
  input  wire logic        sw_menu_escape_switch,
  input  wire logic        sw_up,
  input  wire logic        sw_down,
  input  wire logic        sw_enter,
  input  wire logic        remote_button,
  input  wire logic        poll_valid,
  input  wire logic [2:0]  poll_channel,
  input  wire logic [6:0]  poll_reading,
  input  wire logic        poll_fault,
  input  wire logic        poll_link_ok,
  input  wire logic [7:0]  poll_address,
  input  wire logic [6:0]  poll_twa,
  input  wire logic [6:0]  poll_peak,
  output      logic [31:0] relay_coil,
  output      logic [3:0]  led,
  output      logic [2:0]  page,
  output      logic [3:0]  menu_cursor,
  output      logic        log_valid,
  output      logic [63:0] log_record
);
  localparam int NCH = `GAP_NCH;
  localparam int NB  = `GAP_NBANK;

  // switch conditioning
  logic [4:0] sw_raw;
  logic [4:0] s1, s2, s3, sw_lvl, sw_ev;
  logic [4:0] deb_cnt [5];
  assign sw_raw = {remote_button, sw_enter, sw_down, sw_up, sw_menu_escape_switch};
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s1 <= 5'h00;
      s2 <= 5'h00;
      s3 <= 5'h00;
    end
    else
    begin
      s1 <= sw_raw;
      s2 <= s1;
      s3 <= s2;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_deb
      // level moves only after stable agreement; edge on release side ignored
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          deb_cnt[gi] <= 5'h00;
          sw_lvl[gi]  <= 1'b0;
          sw_ev[gi]   <= 1'b0;
        end
        else
        begin
          sw_ev[gi] <= 1'b0;
          if (s2[gi] != s3[gi] || s3[gi] == sw_lvl[gi])
            deb_cnt[gi] <= 5'h00;
          else if (deb_cnt[gi] == 5'(`GAP_DEB_CYC))
          begin
            sw_lvl[gi]  <= s3[gi];
            sw_ev[gi]   <= s3[gi];
            deb_cnt[gi] <= 5'h00;
          end
          else
            deb_cnt[gi] <= deb_cnt[gi] + 5'h01;
        end
      end
    end
  endgenerate
  logic ev_menu, ev_up, ev_down, ev_enter, ev_remote;
  assign {ev_remote, ev_enter, ev_down, ev_up, ev_menu} = sw_ev;

  // software registers
  logic [4:0]  ctrl;
  logic [2:0]  bank_cfg [NB];
  logic [31:0] ch_cfg   [NCH];
  logic [6:0]  reading  [NCH];
  logic [NCH-1:0] ch_fault, ch_link_err;
  logic [7:0]  sens_cnt;
  gap_ui_t     ui;
  gap_test_t   test_st;
  logic [6:0]  test_lvl;
  logic [4:0]  hh;
  logic [5:0]  mm6, ss6;
  logic [3:0]  mon;
  logic [4:0]  day;
  logic [6:0]  yr;
  logic        wb_hit, wb_wr;
  logic [7:0]  wa;
  logic        do_reset, do_ack;
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // writes land on the edge where the master samples ack high
  assign wb_wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & (&wb_sel_i);
  assign wa     = wb_adr_i[7:0];

  // enter acts as reset/ack only on main display
  assign do_reset = (ui == GAP_MAIN & ev_enter) | ev_remote
                  | (wb_wr & wa == `GAP_REG_CTRL & wb_dat_i[`GAP_CTRL_RESET]);
  assign do_ack   = do_reset
                  | (wb_wr & wa == `GAP_REG_CTRL & wb_dat_i[`GAP_CTRL_ACK]);

  always_ff @(posedge clk)
  begin
    if (reset)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_hit;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctrl <= 5'h00;
      for (int i = 0; i < NB; i++)
        bank_cfg[i] <= 3'h0;
      for (int i = 0; i < NCH; i++)
        ch_cfg[i] <= 32'h00000000;
    end
    else
    begin
      if (test_st == GAP_TEST_DOWN && test_lvl == 7'h00)
        ctrl[`GAP_CTRL_TEST] <= 1'b0;
      if (wb_wr && wa == `GAP_REG_CTRL)
        ctrl <= {wb_dat_i[4], 2'b00, wb_dat_i[1:0]};
      if (wb_wr && wa[7:5] == 3'h1)
        bank_cfg[wa[4:2]] <= wb_dat_i[2:0];
      // thresholds kept as 5% step counts, 0..31
      if (wb_wr && wa[7:5] == 3'h2)
        ch_cfg[wa[4:2]] <= {wb_dat_i[31:30], wb_dat_i[29:0]};
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ui          <= GAP_MAIN;
      menu_cursor <= 4'h0;
    end
    else
    case (ui)
      GAP_MAIN:
        if (ev_menu)
          ui <= GAP_MENU1;
      GAP_MENU1:
        if (ev_menu)
          ui <= GAP_MAIN;
        else if (ev_enter)
          ui <= GAP_MENU2;
        else if (ev_up)
          menu_cursor <= menu_cursor - 4'h1;
        else if (ev_down)
          menu_cursor <= menu_cursor + 4'h1;
      GAP_MENU2:
        if (ev_menu || ev_enter)
          ui <= GAP_MENU1;
      default:
        ui <= GAP_MAIN;
    endcase
  end

  // polled readings, frozen while in menu
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < NCH; i++)
        reading[i] <= 7'h00;
      ch_fault    <= '0;
      ch_link_err <= '0;
      sens_cnt    <= 8'h00;
      log_valid   <= 1'b0;
      log_record  <= 64'h0;
    end
    else
    begin
      log_valid <= 1'b0;
      if (ctrl[`GAP_CTRL_AUTOCFG] && wb_wr && wa == `GAP_REG_CTRL)
        sens_cnt <= 8'h00;
      if (poll_valid && ui == GAP_MAIN)
      begin
        reading[poll_channel]     <= poll_reading;
        ch_fault[poll_channel]    <= poll_fault;
        ch_link_err[poll_channel] <= ~poll_link_ok;
        if (ctrl[`GAP_CTRL_AUTOCFG] && poll_link_ok && poll_address != 8'h00
            && !poll_address[7])
          sens_cnt <= sens_cnt + 8'h01;
        log_valid  <= 1'b1;
        log_record <= {5'h00, yr, mon, day, hh, mm6, ss6, 5'(poll_channel),
                       poll_twa, poll_peak, 7'h0};
      end
    end
  end

  // test ramp, one 5% step per second
  logic [27:0] tick_cnt;
  logic        tick;
  assign tick = tick_cnt == 28'(TICK_CYC - 1);
  always_ff @(posedge clk)
  begin
    if (reset || tick)
      tick_cnt <= 28'h0;
    else
      tick_cnt <= tick_cnt + 28'h1;
  end
  always_ff @(posedge clk)
  begin
    if (reset || !ctrl[`GAP_CTRL_TEST])
    begin
      test_st  <= GAP_TEST_OFF;
      test_lvl <= 7'h00;
    end
    else if (tick)
    case (test_st)
      GAP_TEST_OFF:
        test_st <= GAP_TEST_UP;
      GAP_TEST_UP:
        if (test_lvl >= 7'(`GAP_FULL_PCT))
          test_st <= GAP_TEST_DOWN;
        else
          test_lvl <= test_lvl + 7'(`GAP_STEP_PCT);
      GAP_TEST_DOWN:
        if (test_lvl != 7'h00)
          test_lvl <= test_lvl - 7'(`GAP_STEP_PCT);
      default:
        test_st <= GAP_TEST_OFF;
    endcase
  end

  // per-channel trip, per-bank relays
  logic [2:0] ch_trip [NCH];
  logic [3:0] bank_cause [NB];
  logic [3:0] bank_act   [NB];
  logic [3:0] bank_sil   [NB];
  logic [3:0] out_mask;
  // fault relay stays live under inhibit; latched levels are masked too
  assign out_mask = {1'b1, {3{~ctrl[`GAP_CTRL_INHIBIT]}}};
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_ch
      logic [6:0] val;
      assign val = ctrl[`GAP_CTRL_TEST] ? test_lvl : reading[gi];
      for (genvar l = 0; l < 3; l++)
      begin : g_lvl
        logic [6:0] thr;
        assign thr = 7'(ch_cfg[gi][l*5 +: 5] * `GAP_STEP_PCT);
        assign ch_trip[gi][l] = ch_cfg[gi][15+l] ? (val > thr) : (val < thr);
      end
    end
  endgenerate
  always_comb
  begin
    for (int b = 0; b < NB; b++)
      bank_cause[b] = 4'h0;
    for (int c = 0; c < NCH; c++)
    begin
      bank_cause[ch_cfg[c][22:20]][2:0] = bank_cause[ch_cfg[c][22:20]][2:0]
        | (ctrl[`GAP_CTRL_INHIBIT] ? 3'h0 : ch_trip[c]);
      bank_cause[ch_cfg[c][22:20]][3] = bank_cause[ch_cfg[c][22:20]][3]
        | ch_fault[c] | ch_link_err[c];
    end
  end
  generate
    for (gi = 0; gi < NB; gi++)
    begin : g_bank
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          bank_act[gi] <= 4'h0;
          bank_sil[gi] <= 4'h0;
        end
        else if (ui == GAP_MAIN)
        begin
          for (int k = 0; k < 4; k++)
          begin
            if (bank_cause[gi][k])
              bank_act[gi][k] <= 1'b1;
            else if (!bank_cfg[gi][`GAP_BCFG_LATCH] || do_reset)
              bank_act[gi][k] <= 1'b0;
            if (!bank_cause[gi][k] && !bank_act[gi][k])
              bank_sil[gi][k] <= 1'b0;
            else if (do_ack && bank_cfg[gi][`GAP_BCFG_SILENCE])
              bank_sil[gi][k] <= 1'b1;
          end
        end
      end
      always_ff @(posedge clk)
      begin
        if (reset)
          relay_coil[gi*4 +: 4] <= 4'h0;
        else
          relay_coil[gi*4 +: 4] <= (bank_act[gi] & ~bank_sil[gi] & out_mask)
                                  ^ {4{bank_cfg[gi][`GAP_BCFG_ENERG]}};
      end
    end
  endgenerate
  // or over all banks, then mask like the coils
  logic [3:0] led_any;
  always_comb
  begin
    led_any = 4'h0;
    for (int b = 0; b < NB; b++)
      led_any = led_any | (bank_act[b] & ~bank_sil[b]);
  end
  always_ff @(posedge clk)
  begin
    if (reset)
      led <= 4'h0;
    else
      led <= led_any & out_mask;
  end

  logic [31:0] idle_cnt, page_cnt;
  logic [NCH-1:0] page_hot;
  logic           any_hot;
  logic [2:0]     next_page;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_hot
      assign page_hot[gi] = |ch_trip[gi] | ch_fault[gi] | ch_link_err[gi];
    end
  endgenerate
  assign any_hot = |page_hot;
  always_comb
  begin
    next_page = page + 3'h1;
    for (int k = NCH - 1; k >= 1; k--)
      if (page_hot[3'(page + 3'(k))])
        next_page = 3'(page + 3'(k));
    if (!any_hot)
      next_page = page + 3'h1;
    else if (!page_hot[next_page])
      next_page = page; // single alarm holds
  end
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      page     <= 3'h0;
      idle_cnt <= 32'h0;
      page_cnt <= 32'h0;
    end
    else if (ui == GAP_MAIN && (ev_up || ev_down))
    begin
      page     <= ev_up ? page + 3'h1 : page - 3'h1;
      idle_cnt <= 32'(IDLE_CYC);
      page_cnt <= 32'h0;
    end
    else if (idle_cnt != 32'h0)
      idle_cnt <= idle_cnt - 32'h1;
    else if (page_cnt >= 32'(PAGE_CYC - 1) || (any_hot && !page_hot[page]))
    begin
      page_cnt <= 32'h0;
      page     <= next_page;
    end
    else
      page_cnt <= page_cnt + 32'h1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hh <= 5'h00;
      mm6 <= 6'h00;
      ss6 <= 6'h00;
      mon <= 4'h1;
      day <= 5'h01;
      yr <= 7'h00;
    end
    else if (wb_wr && wa == `GAP_REG_TIME)
    begin
      hh  <= wb_dat_i[20:16];
      mm6 <= wb_dat_i[13:8];
      ss6 <= wb_dat_i[5:0];
    end
    else if (wb_wr && wa == `GAP_REG_DATE)
    begin
      mon <= wb_dat_i[19:16];
      day <= wb_dat_i[12:8];
      yr  <= wb_dat_i[6:0];
    end
    else if (tick)
    begin
      ss6 <= (ss6 == 6'h3b) ? 6'h00 : ss6 + 6'h01;
      if (ss6 == 6'h3b)
        mm6 <= (mm6 == 6'h3b) ? 6'h00 : mm6 + 6'h01;
      if (ss6 == 6'h3b && mm6 == 6'h3b)
      begin
        hh <= (hh == 5'h17) ? 5'h00 : hh + 5'h01;
        if (hh == 5'h17)
        begin
          day <= (day == 5'h1f) ? 5'h01 : day + 5'h01;
          if (day == 5'h1f)
            mon <= (mon == 4'hc) ? 4'h1 : mon + 4'h1;
          if (day == 5'h1f && mon == 4'hc)
            yr <= (yr == 7'h63) ? 7'h00 : yr + 7'h01;
        end
      end
    end
  end

  // read mux; tag field per channel: 0 user, 1..3 alarm level, 4 fault, 5 link failure
  logic [2:0] tag [NCH];
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
      tag[c] = ch_link_err[c] ? 3'h5 : ch_fault[c] ? 3'h4 : ch_trip[c][2] ? 3'h3
             : ch_trip[c][1] ? 3'h2 : ch_trip[c][0] ? 3'h1 : 3'h0;
  end
  always_ff @(posedge clk)
  begin
    if (reset)
      wb_dat_o <= 32'h0;
    else if (wb_hit)
    begin
      wb_dat_o <= 32'h0;
      case (wa)
        `GAP_REG_CTRL:    wb_dat_o <= {27'h0, ctrl};
        `GAP_REG_STATUS:  wb_dat_o <= {20'h0, ui, test_st, 4'h0, led};
        `GAP_REG_RELAY:   wb_dat_o <= relay_coil;
        `GAP_REG_TIME:    wb_dat_o <= {11'h0, hh, 2'h0, mm6, 2'h0, ss6};
        `GAP_REG_DATE:    wb_dat_o <= {12'h0, mon, 3'h0, day, 1'h0, yr};
        `GAP_REG_PAGE:    wb_dat_o <= {24'h0, tag[page], 2'h0, page};
        `GAP_REG_SENSCNT: wb_dat_o <= {24'h0, sens_cnt};
        default:
          if (wa[7:5] == 3'h1)
            wb_dat_o <= {29'h0, bank_cfg[wa[4:2]]};
          else if (wa[7:5] == 3'h2)
            wb_dat_o <= ch_cfg[wa[4:2]];
          else if (wa[7:5] == 3'h3)
            wb_dat_o <= {22'h0, tag[wa[4:2]], reading[wa[4:2]]};
      endcase
    end
  end

  // frozen bank state in menu
  menu_freeze_a: assert property (@(posedge clk) disable iff (reset)
    ui != GAP_MAIN && $past(ui) != GAP_MAIN |-> $stable(bank_act[0]))
    else $error("bank state changed in menu");
  inhibit_relay_a: assert property (@(posedge clk) disable iff (reset)
    ctrl[`GAP_CTRL_INHIBIT] |=> (relay_coil[2:0] ^ {3{$past(bank_cfg[0][`GAP_BCFG_ENERG])}}) == 3'h0)
    else $error("inhibit did not suppress alarms");
  enter_main_a: assert property (@(posedge clk) disable iff (reset)
    ev_enter && ui != GAP_MAIN && !ev_remote && !wb_wr |-> !do_reset)
    else $error("enter reset in menu");
  nonlatch_rel_a: assert property (@(posedge clk) disable iff (reset)
    ui == GAP_MAIN && !bank_cfg[0][0] && !bank_cause[0][0] |=> !bank_act[0][0])
    else $error("non-latching relay held");
  nonsil_ack_a: assert property (@(posedge clk) disable iff (reset)
    !bank_cfg[0][2] |=> !bank_sil[0][0])
    else $error("non-silenceable relay silenced");
  led_mirror_a: assert property (@(posedge clk) disable iff (reset)
    relay_coil[3] != $past(bank_cfg[0][`GAP_BCFG_ENERG]) |-> led[3])
    else $error("led mismatch");
  test_exit_a: assert property (@(posedge clk) disable iff (reset)
    test_st == GAP_TEST_DOWN && test_lvl == 7'h00 |=> !ctrl[`GAP_CTRL_TEST])
    else $error("test mode did not exit");
  swipe_once_a: assert property (@(posedge clk) disable iff (reset)
    sw_ev[1] |=> !sw_ev[1] [*2])
    else $error("switch event repeated");
endmodule

// ### rtl/gap_map.svh
/*
  gas alarm panel: register offsets, field positions, timing counts.
  assumes a 250 MHz clock and a 32-bit classic wishbone register bus.
*/
`ifndef GAP_MAP_SVH
`define GAP_MAP_SVH
`define GAP_NCH            8
`define GAP_NBANK          8
`define GAP_CLK_HZ         250000000
`define GAP_IDLE_S         15
`define GAP_IDLE_CYC       (`GAP_IDLE_S * `GAP_CLK_HZ)
`define GAP_DEB_CYC        16
`define GAP_TICK_CYC       `GAP_CLK_HZ
`define GAP_STEP_PCT       5
`define GAP_FULL_PCT       100
`define GAP_PAGE_CYC       (3 * `GAP_CLK_HZ)
// register byte addresses = word index x4
`define GAP_REG_CTRL       8'h00
`define GAP_REG_STATUS     8'h04
`define GAP_REG_RELAY      8'h08
`define GAP_REG_TIME       8'h0c
`define GAP_REG_DATE       8'h10
`define GAP_REG_PAGE       8'h14
`define GAP_REG_SENSCNT    8'h18
`define GAP_REG_LOG        8'h1c
`define GAP_REG_BANKCFG    8'h20
`define GAP_REG_CHCFG      8'h40
`define GAP_REG_READING    8'h60
// ctrl fields
`define GAP_CTRL_INHIBIT   0
`define GAP_CTRL_TEST      1
`define GAP_CTRL_RESET     2
`define GAP_CTRL_ACK       3
`define GAP_CTRL_AUTOCFG   4
// bank cfg fields
`define GAP_BCFG_LATCH     0
`define GAP_BCFG_ENERG     1
`define GAP_BCFG_SILENCE   2
`endif

// ### rtl/gap_pkg.sv
/*
  gas alarm panel types.
  assumes gap_map.svh for numbers.
*/
package gap_pkg;
  typedef enum logic [1:0] {
    GAP_MAIN  = 2'b00,
    GAP_MENU1 = 2'b01,
    GAP_MENU2 = 2'b11
  } gap_ui_t;
  typedef enum logic [1:0] {
    GAP_TEST_OFF  = 2'b00,
    GAP_TEST_UP   = 2'b01,
    GAP_TEST_DOWN = 2'b11
  } gap_test_t;
endpackage

// ### test/gap_far_side.sv
/*
  model of the far side: polled gas sensors and the operator switches.
  assumes the bench calls its tasks from processes timed on clk.
*/
`timescale 1ns/10ps
module gap_far_side (
  input  wire logic       clk,
  output      logic       poll_valid,
  output      logic [2:0] poll_channel,
  output      logic [6:0] poll_reading,
  output      logic       poll_fault,
  output      logic       poll_link_ok,
  output      logic [7:0] poll_address,
  output      logic [6:0] poll_twa,
  output      logic [6:0] poll_peak,
  output      logic [4:0] sw
);
  initial
  begin
    poll_valid   = 1'b0;
    poll_channel = 3'h0;
    poll_reading = 7'h00;
    poll_fault   = 1'b0;
    poll_link_ok = 1'b1;
    poll_address = 8'h01;
    poll_twa     = 7'h00;
    poll_peak    = 7'h00;
    sw           = 5'h00;
  end
  // one answer, valid for one cycle; fields scrambled once released
  task automatic poll(input int c, input int r, input bit f, input bit lk);
    @(posedge clk);
    poll_valid   <= 1'b1;
    poll_link_ok <= lk;
    poll_channel <= c[2:0];
    poll_reading <= r[6:0];
    poll_fault   <= f;
    poll_address <= 8'h01 + c[7:0];
    poll_twa     <= r[6:0];
    poll_peak    <= r[6:0];
    @(posedge clk);
    poll_valid   <= 1'b0;
    poll_reading <= ~r[6:0];
    poll_fault   <= ~f;
    poll_link_ok <= ~lk;
    poll_twa     <= ~r[6:0];
  endtask
  // magnet held briefly then removed: one swipe
  task automatic swipe(input int i);
    @(posedge clk);
    sw[i] <= 1'b1;
    repeat (30) @(posedge clk);
    sw[i] <= 1'b0;
    repeat (30) @(posedge clk);
  endtask
endmodule

// ### test/gap_panel_bench.sv
/*
  self-checking bench for gap_panel: wishbone master, relay model, scenarios.
  assumes gap_far_side answers polls and makes switch swipes.
*/
`timescale 1ns/10ps
`include "gap_map.svh"
module gap_panel_bench;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, relay_coil, q;
  logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o, log_valid;
  logic [3:0]  wb_sel_i = 4'hf, led, menu_cursor;
  logic        poll_valid, poll_fault, poll_link_ok;
  logic [2:0]  poll_channel, page;
  logic [6:0]  poll_reading, poll_twa, poll_peak;
  logic [7:0]  poll_address;
  logic [4:0]  sw;
  logic [63:0] log_record;
  logic [7:0]  lfsr = 8'h1c;
  int          thr[8][3], bk[8], rd[8], fails, n_tests, logs;
  bit          asc[8][3], flt[8], lnk[8], act[8][4], sil[8][4], inh;
  bit [2:0]    cfg[8];

  always #2 clk = ~clk;
  always @(posedge clk) if (log_valid === 1'b1) logs++;

  gap_far_side fs (.clk, .poll_valid, .poll_channel, .poll_reading, .poll_fault,
    .poll_link_ok, .poll_address, .poll_twa, .poll_peak, .sw);
  gap_panel #(.IDLE_CYC(200), .TICK_CYC(10), .PAGE_CYC(20)) u_dut (.clk, .reset,
    .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .sw_menu_escape_switch(sw[0]), .sw_up(sw[1]), .sw_down(sw[2]),
    .sw_enter(sw[3]), .remote_button(sw[4]), .poll_valid, .poll_channel,
    .poll_reading, .poll_fault, .poll_link_ok, .poll_address, .poll_twa, .poll_peak,
    .relay_coil, .led, .page, .menu_cursor, .log_valid, .log_record);

  function automatic logic [7:0] lfsr_next(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // level trips per bank over all its channels; strict above / below
  function automatic bit cond(int b, int l);
    bit r = 0;
    for (int c = 0; c < 8; c++)
      if (bk[c] == b)
        r |= (l == 3) ? (flt[c] | lnk[c]) : asc[c][l] ? rd[c] > thr[c][l] : rd[c] < thr[c][l];
    return r;
  endfunction
  task automatic model_step(input bit rs, input bit ak);
    for (int b = 0; b < 8; b++)
      for (int l = 0; l < 4; l++)
      begin
        if (cond(b, l))
          act[b][l] = 1;
        else if (!cfg[b][0] || rs)
          act[b][l] = 0;
        if (!cond(b, l))
          sil[b][l] = 0;
        else if (ak && cfg[b][2])
          sil[b][l] = 1;
      end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic check_out;
    logic [31:0] coil;
    logic [31:0] lv;
    coil = '0;
    lv = '0;
    for (int b = 0; b < 8; b++)
      for (int l = 0; l < 4; l++)
      begin
        coil[4*b+l] = (act[b][l] && !sil[b][l] && !(inh && l < 3)) ^ cfg[b][1];
        lv[l] = lv[l] | (act[b][l] && !sil[b][l] && !(inh && l < 3));
      end
    check(coil, relay_coil);
    check(lv, {28'h0, led});
  endtask
  // classic single cycle; held until ack is sampled
  task automatic wb(input bit we, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic ctrl(input logic [31:0] d, input bit rs, input bit ak);
    wb(1'b1, {24'h0, `GAP_REG_CTRL}, d);
    repeat (3) @(posedge clk);
    model_step(rs, ak);
    check_out();
  endtask
  task automatic setbank(input int b, input bit [2:0] v);
    wb(1'b1, {24'h0, `GAP_REG_BANKCFG} + 32'(4 * b), {29'h0, v});
    cfg[b] = v;
    repeat (3) @(posedge clk);
    check_out();
  endtask
  task automatic cfg_ch(input int c, input int t1, input int t2, input int t3,
                        input bit [2:0] a, input int b);
    wb(1'b1, {24'h0, `GAP_REG_CHCFG} + 32'(4 * c),
       {9'h0, 3'(b), 2'b0, a, 5'(t3), 5'(t2), 5'(t1)});
    thr[c] = '{5 * t1, 5 * t2, 5 * t3};
    asc[c] = '{a[0], a[1], a[2]};
    bk[c] = b;
  endtask
  task automatic poll_see(input int c, input int r, input bit f);
    int n = 0;
    int l0 = logs;
    rd[c] = r;
    flt[c] = f;
    fs.poll(c, r, f, !lnk[c]);
    while (logs == l0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (logs == l0) fails++;
    model_step(0, 0);
    repeat (3) @(posedge clk);
    check_out();
    check({6'h0, 5'(c), 7'(r), 7'(r), 7'h0}, {6'h0, log_record[25:0]});
  endtask
  task automatic swipe_cmd(input int i);
    fs.swipe(i);
    model_step(1, 1);
    check_out();
  endtask

  initial
  begin
    #80000;
    fails++;
    end_sim();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check_out();
    // manual page holds through the idle window, then cycling resumes
    fs.swipe(1);
    q = 32'(page);
    repeat (50) @(posedge clk);
    check(q, 32'(page));
    repeat (150) @(posedge clk);
    check(32'h1, 32'(page != q[2:0]));
    wb(1'b1, {24'h0, `GAP_REG_CTRL}, 32'h2);
    wb(1'b0, {24'h0, `GAP_REG_CTRL}, 32'h0);
    check(32'h2, q);
    repeat (600) @(posedge clk);
    wb(1'b0, {24'h0, `GAP_REG_CTRL}, 32'h0);
    check(32'h0, q);
    ctrl(32'h10, 0, 0);
    poll_see(3, 0, 1'b0);
    lnk[3] = 1;
    poll_see(3, 0, 1'b0);
    wb(1'b0, {24'h0, `GAP_REG_READING} + 32'hc, 32'h0);
    check({22'h0, 3'h5, 7'h0}, q);
    lnk[3] = 0;
    poll_see(3, 0, 1'b0);
    wb(1'b0, {24'h0, `GAP_REG_SENSCNT}, 32'h0);
    check(32'h2, q);
    ctrl(32'h0, 0, 0);
    // partial byte select must leave the bank word alone
    wb_sel_i <= 4'h3;
    wb(1'b1, {24'h0, `GAP_REG_BANKCFG} + 32'h14, 32'h7);
    wb_sel_i <= 4'hf;
    wb(1'b0, {24'h0, `GAP_REG_BANKCFG} + 32'h14, 32'h0);
    check(32'h0, q);
    wb(1'b0, 32'hfc, 32'h0);
    check(32'h0, q);
    cfg_ch(0, 4, 10, 16, 3'b111, 0);
    poll_see(0, 60, 1'b0);
    poll_see(0, 50, 1'b0);
    poll_see(0, 10, 1'b0);
    cfg_ch(1, 4, 10, 16, 3'b110, 1);
    poll_see(1, 15, 1'b0);
    poll_see(1, 30, 1'b0);
    poll_see(2, 0, 1'b1);
    poll_see(2, 0, 1'b0);
    setbank(2, 3'b010);
    setbank(2, 3'b000);
    setbank(0, 3'b001);
    poll_see(0, 60, 1'b0);
    ctrl(32'h4, 1, 1);
    poll_see(0, 10, 1'b0);
    ctrl(32'h4, 1, 1);
    setbank(0, 3'b100);
    poll_see(0, 60, 1'b0);
    ctrl(32'h8, 0, 1);
    poll_see(0, 10, 1'b0);
    setbank(0, 3'b000);
    poll_see(0, 60, 1'b0);
    ctrl(32'h8, 0, 1);
    inh = 1;
    ctrl(32'h1, 0, 0);
    poll_see(2, 0, 1'b1);
    inh = 0;
    ctrl(32'h0, 0, 0);
    poll_see(2, 0, 1'b0);
    poll_see(0, 10, 1'b0);
    setbank(0, 3'b001);
    poll_see(0, 60, 1'b0);
    poll_see(0, 10, 1'b0);
    // menu holds readings frozen; enter there is not reset
    fs.swipe(0);
    fs.swipe(2);
    check(32'h1, 32'(menu_cursor));
    fs.swipe(3);
    fs.poll(1, 15, 1'b0, 1'b1);
    repeat (10) @(posedge clk);
    check_out();
    fs.swipe(0);
    fs.swipe(0);
    swipe_cmd(3);
    poll_see(0, 60, 1'b0);
    poll_see(0, 10, 1'b0);
    swipe_cmd(4);
    setbank(0, 3'b000);
    for (int i = 0; i < 24; i++)
    begin
      lfsr = lfsr_next(lfsr);
      poll_see(0, lfsr % 101, 1'b0);
    end
    end_sim();
  end
endmodule
